/* File: src/dulm_mode_mem.sv */
// Mode page parameter store, one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none
module dulm_mode_mem
(
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [8:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read port
    input wire logic [8:0] raddr_i,
    output logic [7:0] rdata_o
);

    logic [7:0] mem_ff [0:511];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_ff[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_ff[raddr_i];
    end

endmodule
`default_nettype wire

/* File: src/dulm_pkg.sv */
// Shared constants, types and lookups for the usage log and mode select block
package dulm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CDB_LO = 8'h00;
    localparam logic [7:0] REG_CDB_HI = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PARAM = 8'h10;
    localparam logic [7:0] REG_EVENT = 8'h14;
    localparam logic [7:0] REG_TEMP = 8'h18;
    localparam logic [7:0] REG_RD_BYTES = 8'h1c;
    localparam logic [7:0] REG_WR_BYTES = 8'h20;
    localparam logic [7:0] REG_LOG_IDX = 8'h24;
    localparam logic [7:0] REG_LOG_DATA = 8'h28;
    localparam logic [7:0] REG_MODE_ADDR = 8'h2c;
    localparam logic [7:0] REG_MODE_DATA = 8'h30;
    localparam logic [7:0] REG_UA = 8'h34;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int EV_HOUR = 0;
    localparam int EV_INFO = 1;
    localparam int EV_MEDIA = 2;
    localparam int EV_HW = 3;
    localparam int EV_REASSIGN = 4;
    localparam int EV_FLASH = 5;
    localparam int ST_SAVE = 3;
    localparam int CDB_PAGE_FORMAT_BIT = 12;
    localparam int CDB_SAVE_PAGES_BIT = 8;
    localparam logic [7:0] OP_MODE_SEL6 = 8'h15;
    localparam logic [7:0] OP_READ6 = 8'h08;
    localparam logic [7:0] OP_READ10 = 8'h28;
    localparam logic [7:0] OP_WRITE6 = 8'h0a;
    localparam logic [7:0] OP_WRITE10 = 8'h2a;
    localparam logic [7:0] OP_WR_VFY = 8'h2e;
    localparam logic [7:0] OP_WR_VFY16 = 8'h8e;
    localparam logic [7:0] LOG_PAGE_CODE = 8'h37;
    localparam logic [15:0] LOG_PAGE_LEN = 16'h0030;
    localparam logic [15:0] LOG_PARAM_CODE = 16'h0000;
    localparam logic [7:0] LOG_PARAM_CTRL = 8'h00;
    localparam logic [7:0] LOG_PARAM_LEN = 8'h2c;
    localparam logic [5:0] LOG_LAST_IDX = 6'h33;
    localparam logic [1:0] HDR_LAST = 2'h3;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_PARAM_LIST = 8'h26;
    localparam logic [7:0] ASC_PARAM_CHANGED = 8'h2a;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int N_INIT = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PS_IDLE = 3'b000,
        PS_HDR = 3'b001,
        PS_BDESC = 3'b010,
        PS_PCODE = 3'b011,
        PS_PLEN = 3'b100,
        PS_PDATA = 3'b101
    } dulm_pstate_t;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } dulm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dulm_axi_rsp_t;

    typedef struct packed {
        dulm_axi_rsp_t axi;
        logic [47:0] cdb;
        logic [2:0] init_id;
        dulm_pstate_t ps;
        logic [7:0] plen;
        logic [7:0] cnt;
        logic [7:0] bdl;
        logic [7:0] seg;
        logic [5:0] pcode;
        logic [7:0] pglen;
        logic sp;
        logic busy;
        logic done;
        logic chk;
        logic changed;
        logic save_req;
        logic [N_INIT-1:0] ua;
        logic [31:0] hours;
        logic [63:0] bytes_rd;
        logic [63:0] bytes_wr;
        logic [7:0] max_temp;
        logic [15:0] glist;
        logic [7:0] iexc;
        logic media_exc;
        logic hw_exc;
        logic [63:0] rd_cmds;
        logic [63:0] wr_cmds;
        logic [15:0] flash_corr;
        logic [5:0] log_idx;
        logic [8:0] mode_addr;
    } dulm_state_t;

    // Device page lengths; zero marks an unsupported page
    function automatic logic [7:0] dulm_page_len(input logic [5:0] pc);
        case (pc)
            6'h01: dulm_page_len = 8'h0a;
            6'h08: dulm_page_len = 8'h0e;
            6'h0a: dulm_page_len = 8'h0a;
            6'h1c: dulm_page_len = 8'h0a;
            default: dulm_page_len = 8'h00;
        endcase
    endfunction

endpackage

/* File: src/dulm_top.sv */
// Usage log page builder and mode select decoder behind an AXI4-Lite slave
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Log page code 37h, parameter 0000h, length 2Ch, control byte zero.
// - Powered-on whole hours, four bytes at page bytes 8 to 11.
// - Highest temperature ever seen, one byte at page byte 28.
// - Reassigned block count, two bytes at page bytes 29 and 30.
// - Non-warning exceptions counted at byte 31, saturating at FFh, reported or not.
// - Sticky media and hardware exception flags in byte 32, rest zero.
// - Eight-byte read command total at bytes 33-40 for READ6 and READ10.
// - Eight-byte write total at 41-48 for WRITE6/10 and WRITE AND VERIFY.
// - Flash correction count, two bytes at page bytes 50 and 51.
// - Opcode 15h decoded: length byte 4, page format bit 4, save bit 0.
// - Page format flag ignored; data always parsed as pages.
// - Save flag 0 applies pages without storing them persistently.
// - Save flag 1 also requests storing pages to the reserved area.
// - Zero parameter length skips data transfer and completes cleanly.
// - Parameter list: 4-byte header, optional block descriptor, then pages.
// - One mode page store shared by all initiators.
// - Page length differing from the device's gives illegal request check.
// - Successful changes post unit attention 2Ah to all other initiators.
module dulm_top
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register bus
    input wire dulm_pkg::dulm_axi_req_t axi_req_i,
    output dulm_pkg::dulm_axi_rsp_t axi_rsp_o
);

    // ------------------------------------------------------------
    // State and memory
    // ------------------------------------------------------------
    dulm_pkg::dulm_state_t st_ff;
    dulm_pkg::dulm_state_t nxt_st;
    logic mem_we;
    logic [8:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [415:0] page_vec;
    localparam int N_INIT = dulm_pkg::N_INIT;

    dulm_mode_mem u_mem
    (
        .clk_i(sys_clk_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(st_ff.mode_addr),
        .rdata_o(mem_rdata)
    );

    assign axi_rsp_o = st_ff.axi;

    // ------------------------------------------------------------
    // Log page image
    // ------------------------------------------------------------
    // Page header and parameter
    assign page_vec = {
        dulm_pkg::LOG_PAGE_CODE, 8'h00, dulm_pkg::LOG_PAGE_LEN,
        dulm_pkg::LOG_PARAM_CODE, dulm_pkg::LOG_PARAM_CTRL, dulm_pkg::LOG_PARAM_LEN,
        st_ff.hours, st_ff.bytes_rd, st_ff.bytes_wr, st_ff.max_temp,
        st_ff.glist, st_ff.iexc, st_ff.media_exc, st_ff.hw_exc, 6'h00,
        st_ff.rd_cmds, st_ff.wr_cmds, 8'h00, st_ff.flash_corr
    };

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic wr_go;
        logic rd_go;
        logic [7:0] wa;
        logic [7:0] ra;
        logic [31:0] wd;
        logic [7:0] b;
        logic [7:0] op;
        logic [7:0] cnt_n;
        logic [5:0] idx;
        wr_go = 1'b0;
        rd_go = 1'b0;
        wa = 8'h00;
        ra = 8'h00;
        wd = 32'h0000_0000;
        b = 8'h00;
        op = 8'h00;
        cnt_n = 8'h00;
        idx = 6'h00;
        nxt_st = st_ff;
        mem_we = 1'b0;
        mem_waddr = {st_ff.pcode[4:0], st_ff.seg[3:0]};
        mem_wdata = 8'h00;

        // Write channel: address and data taken together
        nxt_st.axi.awready = 1'b0;
        nxt_st.axi.wready = 1'b0;
        if (st_ff.axi.bvalid && axi_req_i.bready)
        begin
            nxt_st.axi.bvalid = 1'b0;
        end
        if (axi_req_i.awvalid && axi_req_i.wvalid && !st_ff.axi.bvalid && !st_ff.axi.awready)
        begin
            nxt_st.axi.awready = 1'b1;
            nxt_st.axi.wready = 1'b1;
        end
        wr_go = st_ff.axi.awready && axi_req_i.awvalid && axi_req_i.wvalid;
        wa = axi_req_i.awaddr[7:0];
        wd = merge(32'h0000_0000, axi_req_i.wdata, axi_req_i.wstrb);
        b = wd[7:0];

        // Read channel
        nxt_st.axi.arready = 1'b0;
        if (st_ff.axi.rvalid && axi_req_i.rready)
        begin
            nxt_st.axi.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && !st_ff.axi.rvalid && !st_ff.axi.arready)
        begin
            nxt_st.axi.arready = 1'b1;
        end
        rd_go = st_ff.axi.arready && axi_req_i.arvalid;
        ra = axi_req_i.araddr[7:0];

        if (wr_go)
        begin
            nxt_st.axi.bvalid = 1'b1;
            nxt_st.axi.bresp = dulm_pkg::RESP_OKAY;
            if (wa == dulm_pkg::REG_CDB_LO)
            begin
                nxt_st.cdb[47:16] = merge(st_ff.cdb[47:16], axi_req_i.wdata, axi_req_i.wstrb);
            end
            else if (wa == dulm_pkg::REG_CDB_HI)
            begin
                nxt_st.cdb[15:0] = 16'(merge({16'h0000, st_ff.cdb[15:0]}, axi_req_i.wdata,
                                             axi_req_i.wstrb));
            end
            else if (wa == dulm_pkg::REG_CMD)
            begin
                if (wd[0])
                begin
                    op = st_ff.cdb[47:40];
                    nxt_st.init_id = wd[10:8];
                    nxt_st.done = 1'b0;
                    nxt_st.chk = 1'b0;
                    nxt_st.changed = 1'b0;
                    if (op == dulm_pkg::OP_READ6 || op == dulm_pkg::OP_READ10)
                    begin
                        nxt_st.rd_cmds = st_ff.rd_cmds + 64'h1;
                    end
                    if (op == dulm_pkg::OP_WRITE6 || op == dulm_pkg::OP_WRITE10
                        || op == dulm_pkg::OP_WR_VFY || op == dulm_pkg::OP_WR_VFY16)
                    begin
                        nxt_st.wr_cmds = st_ff.wr_cmds + 64'h1;
                    end
                    if (op == dulm_pkg::OP_MODE_SEL6)
                    begin
                        nxt_st.sp = st_ff.cdb[dulm_pkg::CDB_SAVE_PAGES_BIT + 24];
                        nxt_st.plen = st_ff.cdb[15:8];
                        nxt_st.cnt = 8'h00;
                        nxt_st.seg = 8'h00;
                        if (st_ff.cdb[15:8] == 8'h00)
                        begin
                            nxt_st.done = 1'b1;
                            nxt_st.busy = 1'b0;
                            nxt_st.ps = dulm_pkg::PS_IDLE;
                        end
                        else
                        begin
                            nxt_st.busy = 1'b1;
                            nxt_st.ps = dulm_pkg::PS_HDR;
                        end
                    end
                    else
                    begin
                        nxt_st.done = 1'b1;
                    end
                end
            end
            else if (wa == dulm_pkg::REG_STATUS)
            begin
                if (wd[dulm_pkg::ST_SAVE])
                begin
                    nxt_st.save_req = 1'b0;
                end
            end
            else if (wa == dulm_pkg::REG_PARAM)
            begin
                if (st_ff.busy)
                begin
                    cnt_n = st_ff.cnt + 8'h01;
                    nxt_st.cnt = cnt_n;
                    case (st_ff.ps)
                        dulm_pkg::PS_HDR:
                        begin
                            nxt_st.seg = st_ff.seg + 8'h01;
                            if (st_ff.seg[1:0] == dulm_pkg::HDR_LAST)
                            begin
                                nxt_st.bdl = b;
                                nxt_st.seg = 8'h00;
                                nxt_st.ps = (b == 8'h00) ? dulm_pkg::PS_PCODE : dulm_pkg::PS_BDESC;
                            end
                        end
                        dulm_pkg::PS_BDESC:
                        begin
                            nxt_st.seg = st_ff.seg + 8'h01;
                            if (st_ff.seg + 8'h01 == st_ff.bdl)
                            begin
                                nxt_st.ps = dulm_pkg::PS_PCODE;
                            end
                        end
                        dulm_pkg::PS_PCODE:
                        begin
                            nxt_st.pcode = b[5:0];
                            nxt_st.ps = dulm_pkg::PS_PLEN;
                        end
                        dulm_pkg::PS_PLEN:
                        begin
                            if (b != dulm_pkg::dulm_page_len(st_ff.pcode)
                                || dulm_pkg::dulm_page_len(st_ff.pcode) == 8'h00)
                            begin
                                nxt_st.chk = 1'b1;
                            end
                            nxt_st.pglen = b;
                            nxt_st.seg = 8'h00;
                            nxt_st.ps = (b == 8'h00) ? dulm_pkg::PS_PCODE : dulm_pkg::PS_PDATA;
                        end
                        dulm_pkg::PS_PDATA:
                        begin
                            if (!st_ff.chk)
                            begin
                                mem_we = 1'b1;
                                mem_wdata = b;
                                nxt_st.changed = 1'b1;
                            end
                            nxt_st.seg = st_ff.seg + 8'h01;
                            if (st_ff.seg + 8'h01 == st_ff.pglen)
                            begin
                                nxt_st.ps = dulm_pkg::PS_PCODE;
                            end
                        end
                        default:
                        begin
                            nxt_st.ps = dulm_pkg::PS_IDLE;
                        end
                    endcase
                    if (cnt_n == st_ff.plen)
                    begin
                        if (nxt_st.ps != dulm_pkg::PS_PCODE && st_ff.ps != dulm_pkg::PS_HDR)
                        begin
                            nxt_st.chk = 1'b1;
                        end
                        nxt_st.busy = 1'b0;
                        nxt_st.done = 1'b1;
                        nxt_st.ps = dulm_pkg::PS_IDLE;
                    end
                end
            end
            else if (wa == dulm_pkg::REG_EVENT)
            begin
                if (wd[dulm_pkg::EV_HOUR])
                begin
                    nxt_st.hours = st_ff.hours + 32'h1;
                end
                if ((wd[dulm_pkg::EV_INFO] || wd[dulm_pkg::EV_MEDIA] || wd[dulm_pkg::EV_HW])
                    && st_ff.iexc != 8'hff)
                begin
                    nxt_st.iexc = st_ff.iexc + 8'h01;
                end
                if (wd[dulm_pkg::EV_MEDIA])
                begin
                    nxt_st.media_exc = 1'b1;
                end
                if (wd[dulm_pkg::EV_HW])
                begin
                    nxt_st.hw_exc = 1'b1;
                end
                if (wd[dulm_pkg::EV_REASSIGN])
                begin
                    nxt_st.glist = st_ff.glist + 16'h1;
                end
                if (wd[dulm_pkg::EV_FLASH])
                begin
                    nxt_st.flash_corr = st_ff.flash_corr + 16'h1;
                end
            end
            else if (wa == dulm_pkg::REG_TEMP)
            begin
                if ($signed(b) > $signed(st_ff.max_temp))
                begin
                    nxt_st.max_temp = b;
                end
            end
            else if (wa == dulm_pkg::REG_RD_BYTES)
            begin
                nxt_st.bytes_rd = st_ff.bytes_rd + {32'h0, wd};
            end
            else if (wa == dulm_pkg::REG_WR_BYTES)
            begin
                nxt_st.bytes_wr = st_ff.bytes_wr + {32'h0, wd};
            end
            else if (wa == dulm_pkg::REG_LOG_IDX)
            begin
                nxt_st.log_idx = wd[5:0];
            end
            else if (wa == dulm_pkg::REG_MODE_ADDR)
            begin
                nxt_st.mode_addr = wd[8:0];
            end
            else if (wa == dulm_pkg::REG_UA)
            begin
                nxt_st.ua = st_ff.ua & ~wd[N_INIT-1:0];
            end
            else
            begin
                nxt_st.axi.bresp = dulm_pkg::RESP_SLVERR;
            end
        end

        // Unit attention to others, wins over clear
        if (wr_go && wa == dulm_pkg::REG_PARAM && st_ff.busy && !nxt_st.busy && !nxt_st.chk)
        begin
            if (nxt_st.changed)
            begin
                nxt_st.ua = nxt_st.ua | ~(N_INIT'(1) << st_ff.init_id);
            end
            if (st_ff.sp)
            begin
                nxt_st.save_req = 1'b1;
            end
        end

        if (rd_go)
        begin
            nxt_st.axi.rvalid = 1'b1;
            nxt_st.axi.rresp = dulm_pkg::RESP_OKAY;
            nxt_st.axi.rdata = 32'h0000_0000;
            if (ra == dulm_pkg::REG_CDB_LO)
            begin
                nxt_st.axi.rdata = st_ff.cdb[47:16];
            end
            else if (ra == dulm_pkg::REG_CDB_HI)
            begin
                nxt_st.axi.rdata = {16'h0000, st_ff.cdb[15:0]};
            end
            else if (ra == dulm_pkg::REG_CMD)
            begin
                nxt_st.axi.rdata = {21'h0, st_ff.init_id, 8'h00};
            end
            else if (ra == dulm_pkg::REG_STATUS)
            begin
                nxt_st.axi.rdata = {st_ff.ua,
                                    st_ff.chk ? dulm_pkg::ASC_PARAM_LIST : 8'h00,
                                    st_ff.ua != '0 ? dulm_pkg::ASC_PARAM_CHANGED : 8'h00,
                                    st_ff.chk ? dulm_pkg::SK_ILLEGAL : 4'h0,
                                    st_ff.save_req, st_ff.chk, st_ff.done, st_ff.busy};
            end
            else if (ra == dulm_pkg::REG_LOG_IDX)
            begin
                nxt_st.axi.rdata = {26'h0, st_ff.log_idx};
            end
            else if (ra == dulm_pkg::REG_LOG_DATA)
            begin
                idx = (st_ff.log_idx > dulm_pkg::LOG_LAST_IDX) ? dulm_pkg::LOG_LAST_IDX : st_ff.log_idx;
                nxt_st.axi.rdata = {24'h0, page_vec[(6'(dulm_pkg::LOG_LAST_IDX) - idx) * 8 +: 8]};
                nxt_st.log_idx = (st_ff.log_idx == dulm_pkg::LOG_LAST_IDX) ? 6'h00 : st_ff.log_idx + 6'h01;
            end
            else if (ra == dulm_pkg::REG_MODE_ADDR)
            begin
                nxt_st.axi.rdata = {23'h0, st_ff.mode_addr};
            end
            else if (ra == dulm_pkg::REG_MODE_DATA)
            begin
                nxt_st.axi.rdata = {24'h0, mem_rdata};
            end
            else if (ra == dulm_pkg::REG_UA)
            begin
                nxt_st.axi.rdata = {24'h0, st_ff.ua};
            end
            else
            begin
                nxt_st.axi.rresp = dulm_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule
`default_nettype wire

/* File: src/dulm_top_fix.sv */
// Intentionally empty

/* File: tb/dulm_chk.sv */
// Bus timing checks on the block's ports
`timescale 1ns/10ps
`default_nettype none
module dulm_chk
(
    // Watched ports
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire dulm_pkg::dulm_axi_req_t axi_req_i,
    input wire dulm_pkg::dulm_axi_rsp_t axi_rsp_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    aw_pair_a: assert property (axi_rsp_o.awready |-> axi_rsp_o.wready)
        else $error("write channels split");
    w_cause_a: assert property (axi_rsp_o.awready |-> $past(axi_req_i.awvalid && axi_req_i.wvalid))
        else $error("write taken without request");
    b_lat_a: assert property (axi_rsp_o.awready |=> axi_rsp_o.bvalid)
        else $error("write answer late");
    b_drop_a: assert property (axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid)
        else $error("write answer stuck");
    b_refuse_a: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready)
        else $error("write taken while answer pending");
    r_lat_a: assert property (axi_rsp_o.arready |=> axi_rsp_o.rvalid ##1 !axi_rsp_o.rvalid)
        else $error("read answer timing");
    unmapped_err_a: assert property (axi_rsp_o.awready && axi_req_i.awaddr[7:0] > 8'h34
        |=> axi_rsp_o.bresp == dulm_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    rst_quiet_a: assert property ($past(rst_i) |-> !axi_rsp_o.bvalid && !axi_rsp_o.rvalid)
        else $error("answer right after reset");
    cover property (axi_rsp_o.bvalid && axi_rsp_o.bresp == dulm_pkg::RESP_SLVERR);
    cover property (axi_rsp_o.rvalid);
    cover property (axi_rsp_o.awready);
endmodule
bind dulm_top dulm_chk u_dulm_chk (.sys_clk_i, .rst_i, .axi_req_i, .axi_rsp_o);
`default_nettype wire

/* File: tb/dulm_host.sv */
// Register bus master standing in for the initiator side
`timescale 1ns/10ps
`default_nettype none
module dulm_host
(
    // Bus
    input wire logic clk_i,
    input wire dulm_pkg::dulm_axi_rsp_t rsp_i,
    output dulm_pkg::dulm_axi_req_t req_o
);
    initial req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req_o <= '{1'b1, {24'h0, a}, 1'b1, d, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0};
        do @(posedge clk_i); while (!rsp_i.awready);
        req_o <= '{1'b0, 32'h0, 1'b0, 32'h0, 4'h0, 1'b1, 1'b0, 32'h0, 1'b0};
        do @(posedge clk_i); while (!rsp_i.bvalid);
        req_o <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        req_o <= '{1'b0, 32'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, {24'h0, a}, 1'b1};
        do @(posedge clk_i); while (!rsp_i.arready);
        req_o.arvalid <= 1'b0;
        do @(posedge clk_i); while (!rsp_i.rvalid);
        d = rsp_i.rdata;
        req_o <= '0;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_drive_usage_log_and_mode_select.sv */
// Self-checking bench for the usage log and mode select block
`timescale 1ns/10ps
`default_nettype none
module test_drive_usage_log_and_mode_select;
    logic sys_clk_i;
    logic rst_i;
    dulm_pkg::dulm_axi_req_t req;
    dulm_pkg::dulm_axi_rsp_t rsp;
    int bad_count;
    int comparisons;
    logic [31:0] d;
    dulm_top u_dulm_top (.sys_clk_i, .rst_i, .axi_req_i(req), .axi_rsp_o(rsp));
    dulm_host u_dulm_host (.clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic cmd(input logic [47:0] cdb, input logic [2:0] id);
        u_dulm_host.wr(dulm_pkg::REG_CDB_LO, cdb[47:16]);
        u_dulm_host.wr(dulm_pkg::REG_CDB_HI, {16'h0, cdb[15:0]});
        u_dulm_host.wr(dulm_pkg::REG_CMD, {21'h0, id, 8'h01});
    endtask
    task automatic t_log_page();
        logic [7:0] ops [0:5] = '{8'h08, 8'h28, 8'h0a, 8'h2a, 8'h2e, 8'h8e};
        int ix [11] = '{0, 3, 7, 11, 28, 30, 31, 32, 40, 48, 51};
        logic [7:0] vx [11] = '{8'h37, 8'h30, 8'h2c, 8'h02, 8'h2e, 8'h01, 8'h03, 8'hc0, 8'h02, 8'h04, 8'h01};
        logic [31:0] pg [0:51] = '{default: 32'h0};
        foreach (ix[i]) pg[ix[i]] = {24'h0, vx[i]};
        foreach (ops[i]) cmd({ops[i], 40'h0}, 3'h0);
        for (int i = 0; i < 7; i++) u_dulm_host.wr(dulm_pkg::REG_EVENT, 32'h1 << (i % 6));
        u_dulm_host.wr(dulm_pkg::REG_TEMP, 32'h2e);
        u_dulm_host.wr(dulm_pkg::REG_TEMP, 32'hf0);
        u_dulm_host.wr(8'h3c, 32'hffffffff);
        u_dulm_host.wr(dulm_pkg::REG_LOG_IDX, 32'h0);
        for (int i = 0; i < 52; i++)
        begin
            u_dulm_host.rd(dulm_pkg::REG_LOG_DATA, d);
            check(d, pg[i]);
        end
    endtask
    task automatic t_mode(input logic [7:0] len, input logic [7:0] fl, input logic [31:0] want);
        cmd({8'h15, fl, 16'h0, len, 8'h00}, 3'h2);
        for (int i = 0; i < len; i++)
            u_dulm_host.wr(dulm_pkg::REG_PARAM, (i == 3) ? 32'h8 : (i == 12) ? 32'h1 : (i == 13) ? 32'ha
                           : (i > 13) ? 32'(i) + {24'h0, fl} : 32'h0);
        u_dulm_host.rd(dulm_pkg::REG_STATUS, d);
        check(d, want);
        u_dulm_host.wr(dulm_pkg::REG_MODE_ADDR, 32'h19);
        u_dulm_host.rd(dulm_pkg::REG_MODE_DATA, d);
        if (len == 8'h18) check(d, 32'h17 + {24'h0, fl});
        u_dulm_host.wr(dulm_pkg::REG_UA, 32'hff);
        u_dulm_host.wr(dulm_pkg::REG_STATUS, 32'h8);
    endtask
    task automatic conclude();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #1000000;
        bad_count++;
        conclude();
    end
    initial
    begin
        bad_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_log_page();
        t_mode(8'h00, 8'h10, 32'h00000002);
        t_mode(8'h0d, 8'h10, 32'h00260056);
        t_mode(8'h18, 8'h00, 32'hfb002a02);
        t_mode(8'h18, 8'h01, 32'hfb002a0a);
        conclude();
    end
endmodule
`default_nettype wire
